// ### core/alc_params.svh
// constants of the ambient light and keypad light controller
// assumes a 100 MHz clock and 32-bit classic wishbone word access
`ifndef ALC_PARAMS_SVH
`define ALC_PARAMS_SVH
`define ALC_IDX_CTRL    6'h00
`define ALC_IDX_HOSTCUR 6'h01
`define ALC_IDX_SRC     6'h02
`define ALC_IDX_PWMSEL  6'h03
`define ALC_IDX_SLOPE   6'h0a
`define ALC_IDX_CAL     6'h0c
`define ALC_IDX_DATA    6'h0d
`define ALC_IDX_PADPWM  6'h0e
`define ALC_IDX_PADTHR  6'h0f
`define ALC_IDX_LUT_HI  2'b01
`define ALC_BIT_FOLLOW  1
`define ALC_BIT_MAIN    3
`define ALC_BIT_AMBIENT_CTRL_ENABLE   7
`define ALC_BIT_HOST    5
`define ALC_BIT_CAI     7
`define ALC_BIT_PWMSEL  0
`define ALC_BIT_SYNC    7
`define ALC_BIT_TYPE    6
`define ALC_RST_CTRL    8'h00
`define ALC_RST_HOSTCUR 8'h00
`define ALC_RST_SRC     8'h00
`define ALC_RST_PWMSEL  8'h00
`define ALC_RST_SLOPE   8'h00
`define ALC_RST_CAL     8'h00
`define ALC_RST_PADPWM  8'h00
`define ALC_RST_PADTHR  8'ha3
`define ALC_LUT_RST {8'hf9,8'he4,8'hd5,8'hc6,8'hb6,8'ha7,8'h98,8'h89,\
8'h79,8'h6a,8'h5b,8'h4c,8'h3c,8'h2d,8'h1e,8'h0f}
`define ALC_LOG_BOUNDS {8'hc8,8'h91,8'h69,8'h4b,8'h36,8'h27,8'h1c,8'h14,\
8'h0e,8'h0a,8'h07,8'h05,8'h03,8'h02,8'h01,8'h00}
`define ALC_BYP_BOUNDS {8'hb6,8'ha9,8'h9c,8'h90,8'h84,8'h78,8'h6c,8'h60,\
8'h54,8'h48,8'h3c,8'h30,8'h25,8'h1b,8'h12,8'h00}
`define ALC_CLK_MHZ       100
`define ALC_MEAS_P0_MS    520
`define ALC_MEAS_P1_MS    1050
`define ALC_MEAS_P2_MS    1570
`define ALC_MEAS_P3_MS    2100
`define ALC_MEAS_P0_CYC   (`ALC_MEAS_P0_MS * `ALC_CLK_MHZ * 1000)
`define ALC_MEAS_P1_CYC   (`ALC_MEAS_P1_MS * `ALC_CLK_MHZ * 1000)
`define ALC_MEAS_P2_CYC   (`ALC_MEAS_P2_MS * `ALC_CLK_MHZ * 1000)
`define ALC_MEAS_P3_CYC   (`ALC_MEAS_P3_MS * `ALC_CLK_MHZ * 1000)
`define ALC_DISCARD_MS    64
`define ALC_DISCARD_CYC   (`ALC_DISCARD_MS * `ALC_CLK_MHZ * 1000)
`define ALC_WINDOW_US     16400
`define ALC_SAMPLES       16
`define ALC_SAMPLE_CYC    (`ALC_WINDOW_US * `ALC_CLK_MHZ / `ALC_SAMPLES)
`define ALC_PWM_HZ        500
`define ALC_PWM_STEP_CYC  (`ALC_CLK_MHZ * 1000000 / `ALC_PWM_HZ / 16)
`define ALC_SLOPE_UNIT_US 256
`define ALC_SLOPE_CYC     (`ALC_SLOPE_UNIT_US * `ALC_CLK_MHZ)
`define ALC_FADE_UNIT_US  1000
`define ALC_FADE_CYC      (`ALC_FADE_UNIT_US * `ALC_CLK_MHZ)
`endif

// ### core/alc_pkg.sv
// types of the ambient light and keypad light controller
// assumes nothing beyond a systemverilog compiler
package alc_pkg;
  // classic wishbone request, all master-driven signals
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;
  // measurement sequencer states
  typedef enum logic [1:0] {
    MEAS_IDLE,
    MEAS_WARM,
    MEAS_SAMPLE
  } meas_state_t;
endpackage

// ### core/ambient_light_keypad_ctrl.sv
// ambient light readout, backlight current ramp and keypad light control
// assumes a synchronous wishbone master and an adc bus arriving from pins
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "alc_params.svh"
module ambient_light_keypad_ctrl #(
  parameter int unsigned MEAS_P0_CYC   = `ALC_MEAS_P0_CYC,
  parameter int unsigned MEAS_P1_CYC   = `ALC_MEAS_P1_CYC,
  parameter int unsigned MEAS_P2_CYC   = `ALC_MEAS_P2_CYC,
  parameter int unsigned MEAS_P3_CYC   = `ALC_MEAS_P3_CYC,
  parameter int unsigned DISCARD_CYC   = `ALC_DISCARD_CYC,
  parameter int unsigned SAMPLE_CYC    = `ALC_SAMPLE_CYC,
  parameter int unsigned PWM_STEP_CYC  = `ALC_PWM_STEP_CYC,
  parameter int unsigned SLOPE_CYC     = `ALC_SLOPE_CYC,
  parameter int unsigned FADE_CYC      = `ALC_FADE_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  alc_pkg::wb_req_t      wb_req_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic [7:0]       adc_data_i,
  input  wire logic [7:0]       content_pwm_input_i,
  output logic                  sensor_supply_en_o,
  output logic                  adc_power_en_o,
  output logic                  adc_sample_o,
  output logic [7:0]            main_current_o,
  output logic                  pad_light_o
);
  // software registers
  logic [7:0] ctrl_reg, hostcur_reg, src_reg, pwmsel_reg;
  logic [7:0] slope_reg, cal_reg, padpwm_reg, padthr_reg;
  logic [7:0] lut_reg [16];
  logic       ack_reg;
  logic [31:0] dat_reg;
  // measurement state
  alc_pkg::meas_state_t state_reg;
  logic [31:0] tmr_reg, per_reg;
  logic [3:0]  n_reg, amb_code_reg;
  logic [11:0] acc_reg;
  logic        new_code_reg, sample_reg;
  logic [7:0]  adc_s1_reg, adc_s2_reg;
  // output stage state
  logic [7:0]  cur_reg;
  logic [31:0] rtmr_reg, pcnt_reg, ftmr_reg;
  logic [4:0]  eff_reg;
  logic        pad_off_reg, pad_reg, supply_reg, adcpwr_reg;

  // map a corrected reading to a code by counting passed bounds
  function automatic logic [3:0] quantize(input logic [7:0] r,
                                          input logic bypass);
    logic [127:0] b;
    logic [3:0]   c;
    b = bypass ? `ALC_BYP_BOUNDS : `ALC_LOG_BOUNDS;
    c = 4'h0;
    for (int i = 1; i < 16; i++)
      if (r >= b[i*8 +: 8])
        c = c + 4'h1;
    return c;
  endfunction

  // field decode
  wire        ambient_ctrl_enable     = ctrl_reg[`ALC_BIT_AMBIENT_CTRL_ENABLE];
  wire        follow    = ctrl_reg[`ALC_BIT_FOLLOW];
  wire        main_on   = ctrl_reg[`ALC_BIT_MAIN];
  wire        host_bit  = src_reg[`ALC_BIT_HOST];
  wire        cai_sel   = src_reg[`ALC_BIT_CAI];
  wire        pwm_sel   = pwmsel_reg[`ALC_BIT_PWMSEL];
  wire        sync_sel  = cal_reg[`ALC_BIT_SYNC];
  wire        bypass    = cal_reg[`ALC_BIT_TYPE];
  wire [1:0]  per_sel   = cal_reg[5:4];
  wire [3:0]  cal_off   = cal_reg[3:0];
  wire [3:0]  up_code   = slope_reg[7:4];
  wire [3:0]  dn_code   = slope_reg[3:0];
  wire [3:0]  duty_fld  = padpwm_reg[3:0];
  wire [1:0]  fade_fld  = padpwm_reg[5:4];
  wire [3:0]  thr       = padthr_reg[7:4];
  wire [3:0]  hyst      = padthr_reg[3:0];

  // bus decode; index is the word address
  wire        req       = wb_req_i.cyc & wb_req_i.stb;
  wire [5:0]  idx       = wb_req_i.adr[7:2];
  wire        hit_lut   = idx[5:4] == `ALC_IDX_LUT_HI;
  wire        wr_en     = req & ack_reg & wb_req_i.we & wb_req_i.sel[0];
  wire [7:0]  wdat      = wb_req_i.dat[7:0];
  wire [7:0]  rd_byte   =
    hit_lut                    ? lut_reg[idx[3:0]] :
    idx == `ALC_IDX_CTRL       ? ctrl_reg :
    idx == `ALC_IDX_HOSTCUR    ? hostcur_reg :
    idx == `ALC_IDX_SRC        ? src_reg :
    idx == `ALC_IDX_PWMSEL     ? pwmsel_reg :
    idx == `ALC_IDX_SLOPE      ? slope_reg :
    idx == `ALC_IDX_CAL        ? cal_reg :
    idx == `ALC_IDX_DATA       ? {4'h0, amb_code_reg} :
    idx == `ALC_IDX_PADPWM     ? padpwm_reg :
    idx == `ALC_IDX_PADTHR     ? padthr_reg : 8'h00;

  // wishbone slave: one wait state, unmapped reads zero, writes dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg     <= 1'b0;
      dat_reg     <= 32'h0;
      ctrl_reg    <= `ALC_RST_CTRL;
      hostcur_reg <= `ALC_RST_HOSTCUR;
      src_reg     <= `ALC_RST_SRC;
      pwmsel_reg  <= `ALC_RST_PWMSEL;
      slope_reg   <= `ALC_RST_SLOPE;
      cal_reg     <= `ALC_RST_CAL;
      padpwm_reg  <= `ALC_RST_PADPWM;
      padthr_reg  <= `ALC_RST_PADTHR;
      for (int i = 0; i < 16; i++)
        lut_reg[i] <= 8'(`ALC_LUT_RST >> (i * 8));
    end
    else if (ce_i)
    begin
      ack_reg <= req & ~ack_reg;
      if (req & ~ack_reg)
        dat_reg <= {24'h0, rd_byte};
      if (wr_en)
      begin
        if (hit_lut)
          lut_reg[idx[3:0]] <= wdat;
        unique case (idx)
          `ALC_IDX_CTRL:    ctrl_reg    <= wdat;
          `ALC_IDX_HOSTCUR: hostcur_reg <= wdat;
          `ALC_IDX_SRC:     src_reg     <= wdat;
          `ALC_IDX_PWMSEL:  pwmsel_reg  <= wdat;
          `ALC_IDX_SLOPE:   slope_reg   <= wdat;
          `ALC_IDX_CAL:     cal_reg     <= wdat;
          `ALC_IDX_PADPWM:  padpwm_reg  <= wdat;
          `ALC_IDX_PADTHR:  padthr_reg  <= wdat;
          default:          ;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // adc bus comes from pins: two flops before use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      adc_s1_reg <= 8'h00;
      adc_s2_reg <= 8'h00;
    end
    else if (ce_i)
    begin
      adc_s1_reg <= adc_data_i;
      adc_s2_reg <= adc_s1_reg;
    end
  end

  // average, signed offset, clamp, quantize on the last sample
  wire [11:0] sum_next  = acc_reg + {4'h0, adc_s2_reg};
  wire [9:0]  corr      = {2'b00, sum_next[11:4]}
                          + {{6{cal_off[3]}}, cal_off};
  wire [7:0]  clamped   = corr[9] ? 8'h00 :
                          corr[8] ? 8'hff : corr[7:0];
  wire [3:0]  code_next = quantize(clamped, bypass);
  wire [31:0] per_cyc   = per_sel == 2'd0 ? MEAS_P0_CYC :
                          per_sel == 2'd1 ? MEAS_P1_CYC :
                          per_sel == 2'd2 ? MEAS_P2_CYC : MEAS_P3_CYC;

  // period timer; restarts with each enable so the first run is prompt
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      per_reg <= 32'h0;
    else if (ce_i)
    begin
      if (!ambient_ctrl_enable)
        per_reg <= 32'h0;
      else if (per_reg == 32'h0)
        per_reg <= per_cyc - 32'h1;
      else
        per_reg <= per_reg - 32'h1;
    end
  end

  // measurement sequencer: warm-up discard, then sixteen timed samples
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg    <= alc_pkg::MEAS_IDLE;
      tmr_reg      <= 32'h0;
      n_reg        <= 4'h0;
      acc_reg      <= 12'h0;
      amb_code_reg <= 4'h0;
      new_code_reg <= 1'b0;
      sample_reg   <= 1'b0;
    end
    else if (ce_i)
    begin
      new_code_reg <= 1'b0;
      sample_reg   <= 1'b0;
      if (!ambient_ctrl_enable)
        state_reg <= alc_pkg::MEAS_IDLE;
      else
        unique case (state_reg)
          alc_pkg::MEAS_IDLE:
            if (per_reg == 32'h0)
            begin
              tmr_reg   <= DISCARD_CYC - 32'h1;
              state_reg <= alc_pkg::MEAS_WARM;
            end
          alc_pkg::MEAS_WARM:
            if (tmr_reg == 32'h0)
            begin
              tmr_reg   <= SAMPLE_CYC - 32'h1;
              n_reg     <= 4'h0;
              acc_reg   <= 12'h0;
              state_reg <= alc_pkg::MEAS_SAMPLE;
            end
            else
              tmr_reg <= tmr_reg - 32'h1;
          alc_pkg::MEAS_SAMPLE:
            if (tmr_reg == 32'h0)
            begin
              sample_reg <= 1'b1;
              acc_reg    <= sum_next;
              n_reg      <= n_reg + 4'h1;
              tmr_reg    <= SAMPLE_CYC - 32'h1;
              if (n_reg == 4'hf)
              begin
                amb_code_reg <= code_next;
                new_code_reg <= 1'b1;
                state_reg    <= alc_pkg::MEAS_IDLE;
              end
            end
            else
              tmr_reg <= tmr_reg - 32'h1;
        endcase
    end
  end
  assign adc_sample_o = sample_reg;

  // backlight target; content pwm path skips the ramp
  wire        use_alc   = ambient_ctrl_enable & main_on;
  wire [7:0]  target    = !main_on ? 8'h00 :
                          use_alc ? lut_reg[amb_code_reg] :
                          cai_sel ? content_pwm_input_i : hostcur_reg;
  wire        going_up  = target > cur_reg;
  wire [3:0]  step_code = going_up ? up_code : dn_code;
  wire [31:0] step_cyc  = 32'(step_code) * SLOPE_CYC;
  wire        jump      = !main_on | (cai_sel & !use_alc)
                          | step_code == 4'h0;

  // ramp one current step per slope time toward the target
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur_reg  <= 8'h00;
      rtmr_reg <= 32'h0;
    end
    else if (ce_i)
    begin
      if (jump || cur_reg == target)
      begin
        cur_reg  <= target;
        rtmr_reg <= 32'h0;
      end
      else if (rtmr_reg >= step_cyc - 32'h1)
      begin
        cur_reg  <= going_up ? cur_reg + 8'h1 : cur_reg - 8'h1;
        rtmr_reg <= 32'h0;
      end
      else
        rtmr_reg <= rtmr_reg + 32'h1;
    end
  end
  assign main_current_o = cur_reg;

  // keypad hysteresis: off at threshold, on at threshold-hyst-1
  wire signed [5:0] on_lvl = $signed({2'b00, thr})
                             - $signed({2'b00, hyst}) - 6'sd1;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pad_off_reg <= 1'b0;
    else if (ce_i && new_code_reg)
    begin
      if (amb_code_reg >= thr)
        pad_off_reg <= 1'b1;
      else if ($signed({2'b00, amb_code_reg}) <= on_lvl)
        pad_off_reg <= 1'b0;
    end
  end

  // 500 Hz pwm; duty in sixteenths, 15 gives full on
  wire [4:0]  duty_tgt  = pwm_sel ? {1'b0, duty_fld} + 5'h1 : 5'h0;
  wire [31:0] fade_cyc  = 32'(fade_fld) * FADE_CYC;
  wire        pwm_out   = pcnt_reg < 32'(eff_reg) * PWM_STEP_CYC;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pcnt_reg <= 32'h0;
      ftmr_reg <= 32'h0;
      eff_reg  <= 5'h0;
    end
    else if (ce_i)
    begin
      pcnt_reg <= pcnt_reg >= 32'd16 * PWM_STEP_CYC - 32'h1 ?
                  32'h0 : pcnt_reg + 32'h1;
      if (fade_fld == 2'b00 || eff_reg == duty_tgt)
      begin
        eff_reg  <= duty_tgt;
        ftmr_reg <= 32'h0;
      end
      else if (ftmr_reg >= fade_cyc - 32'h1)
      begin
        eff_reg  <= eff_reg < duty_tgt ? eff_reg + 5'h1
                                       : eff_reg - 5'h1;
        ftmr_reg <= 32'h0;
      end
      else
        ftmr_reg <= ftmr_reg + 32'h1;
    end
  end

  // keypad source priority and power outputs, all registered
  wire pad_next = (ambient_ctrl_enable & follow) ? !pad_off_reg :
                  pwm_sel          ? pwm_out :
                                     host_bit;
  wire measuring = state_reg != alc_pkg::MEAS_IDLE;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pad_reg    <= 1'b0;
      supply_reg <= 1'b0;
      adcpwr_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      pad_reg    <= pad_next;
      supply_reg <= ambient_ctrl_enable & (!sync_sel | measuring);
      adcpwr_reg <= measuring;
    end
  end
  assign pad_light_o        = pad_reg;
  assign sensor_supply_en_o = supply_reg;
  assign adc_power_en_o     = adcpwr_reg;

  // checks next to the logic they guard
  property p_main_off;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !main_on) |=> main_current_o == 8'h00;
  endproperty
  a_main_off: assert property (p_main_off)
    else $error("current not zero with main backlight off");

  property p_alc_lut;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && use_alc && slope_reg == 8'h00)
      |=> main_current_o == $past(lut_reg[amb_code_reg]);
  endproperty
  a_alc_lut: assert property (p_alc_lut)
    else $error("ambient current not taken from table");

  property p_ramp_step;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && main_on && !cai_sel && up_code != 4'h0 && dn_code != 4'h0)
      |=> (cur_reg == $past(cur_reg) + 8'h1 || cur_reg == $past(cur_reg)
           || cur_reg == $past(cur_reg) - 8'h1);
  endproperty
  a_ramp_step: assert property (p_ramp_step)
    else $error("ramp moved more than one step");

  property p_adc_off;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == alc_pkg::MEAS_IDLE && $past(state_reg)
     == alc_pkg::MEAS_IDLE) |-> !adc_power_en_o;
  endproperty
  a_adc_off: assert property (p_adc_off)
    else $error("converter powered outside a measurement");

  property p_discard;
    @(posedge clk_i) disable iff (rst_i)
    state_reg == alc_pkg::MEAS_WARM |-> !adc_sample_o;
  endproperty
  a_discard: assert property (p_discard)
    else $error("sample taken during discard time");

  property p_store;
    @(posedge clk_i) disable iff (rst_i)
    new_code_reg |-> adc_sample_o && $past(n_reg) == 4'hf;
  endproperty
  a_store: assert property (p_store)
    else $error("ambient data stored before sixteen samples");

  property p_hyst_off;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && new_code_reg && amb_code_reg >= thr) |=> pad_off_reg;
  endproperty
  a_hyst_off: assert property (p_hyst_off)
    else $error("keypad not off at threshold");

  property p_override;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && ambient_ctrl_enable && follow) |=> pad_light_o == !$past(pad_off_reg);
  endproperty
  a_override: assert property (p_override)
    else $error("ambient decision did not drive keypad");

  property p_host_key;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !(ambient_ctrl_enable && follow) && !pwm_sel)
      |=> pad_light_o == $past(host_bit);
  endproperty
  a_host_key: assert property (p_host_key)
    else $error("keypad not following host bit");

  property p_supply;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && ambient_ctrl_enable && !sync_sel) |=> sensor_supply_en_o;
  endproperty
  a_supply: assert property (p_supply)
    else $error("sensor supply off while unsynced and enabled");

  c_measure: cover property (@(posedge clk_i) new_code_reg);
  c_ramp: cover property (@(posedge clk_i)
    rtmr_reg != 32'h0 ##1 rtmr_reg == 32'h0 && cur_reg != target);
  c_pad_off: cover property (@(posedge clk_i) $fell(pad_light_o));
endmodule // ambient_light_keypad_ctrl

// ### verif/light_sensor_model.sv
// light sensor plus its analog front end, seen from the converter pins
// assumes supply and converter enables from the controller, one clock
`timescale 1ns/1ps
module light_sensor_model #(
  parameter int SETTLE = 12
) (
  input  wire logic       clk_i,
  input  wire logic       supply_en_i,
  input  wire logic       adc_power_en_i,
  input  wire logic [7:0] light_level_i,
  output logic      [7:0] adc_data_o
);
  int warm = SETTLE;
  initial adc_data_o = 8'h5a;
  // unpowered or settling front end gives a toggling pattern, never the
  // last value, so a reading taken too early shows up as a wrong code
  always @(posedge clk_i)
  begin
    if (supply_en_i && adc_power_en_i && warm != 0)
      warm <= warm - 1;
    else if (!(supply_en_i && adc_power_en_i))
      warm <= SETTLE;
    if (supply_en_i && adc_power_en_i && warm == 0)
      adc_data_o <= light_level_i;
    else
      adc_data_o <= ~adc_data_o;
  end
endmodule // light_sensor_model

// ### verif/tb_top.sv
// bench: wishbone register tasks, sensor model on the converter pins
// assumes the controller built with short counts, single 100 MHz clock
`timescale 1ns/1ps
module tb_top;
  localparam int DIS = 20;
  localparam int P0 = 400;
  localparam int P1 = 800;
  localparam int P2 = 1200;
  localparam int P3 = 1600;
  localparam int SCYC = 4;
  localparam int STP = 4;
  localparam int SLP = 3;
  localparam int FD = 3;
  // clock enable and content current are driven so both paths get exercised
  logic             ce = 1'b1;
  logic [7:0]       cpi = 8'h33;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  alc_pkg::wb_req_t req = '0;
  logic [31:0]      wb_dat_o;
  logic             wb_ack_o, supply, pwr, smp, pad_light_o;
  logic [7:0]       adc, main_current_o;
  logic [7:0]       lvl = 8'h00;
  int               err_total = 0;
  int               n_checks = 0;
  int               n;
  logic [7:0] lut [16] = '{8'h0f, 8'h1e, 8'h2d, 8'h3c, 8'h4c, 8'h5b,
    8'h6a, 8'h79, 8'h89, 8'h98, 8'ha7, 8'hb6, 8'hc6, 8'hd5, 8'he4, 8'hf9};
  logic [7:0] tv [14] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h35, 8'h36,
    8'hc7, 8'hc8, 8'hff, 8'h11, 8'h12, 8'hb5, 8'hb6, 8'hff};
  logic [3:0] tc [14] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'ha, 4'hb, 4'he,
    4'hf, 4'hf, 4'h0, 4'h1, 4'he, 4'hf, 4'hf};
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  // counts shortened so one measurement lasts about a hundred cycles
  ambient_light_keypad_ctrl #(.MEAS_P0_CYC(P0), .MEAS_P1_CYC(P1),
    .MEAS_P2_CYC(P2), .MEAS_P3_CYC(P3), .DISCARD_CYC(DIS),
    .SAMPLE_CYC(SCYC), .PWM_STEP_CYC(STP), .SLOPE_CYC(SLP),
    .FADE_CYC(FD)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_req_i(req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_data_i(adc),
    .content_pwm_input_i(cpi), .sensor_supply_en_o(supply),
    .adc_power_en_o(pwr), .adc_sample_o(smp),
    .main_current_o(main_current_o), .pad_light_o(pad_light_o));
  light_sensor_model sensor (.clk_i(clk_i), .supply_en_i(supply),
    .adc_power_en_i(pwr), .light_level_i(lvl), .adc_data_o(adc));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; request held until ack is seen at an edge
  task automatic wbx(input logic w, input logic [5:0] i,
      input logic [7:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, {i, 2'b00}, 4'hf, {24'h0, d}};
    while (wb_ack_o !== 1'b1 && k < 50)
    begin
      @(posedge clk_i);
      k++;
    end
    q = wb_dat_o;
    req <= '0;
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [31:0] q;
    wbx(1'b1, i, d, q);
  endtask
  task automatic rdc(input logic [5:0] i, input logic [31:0] e);
    logic [31:0] q;
    wbx(1'b0, i, 8'h00, q);
    chk(q, e);
  endtask
  // level changes only between measurements; one whole run is watched
  task automatic meas(input logic [7:0] v, input logic [3:0] c,
      input logic s);
    int t, f, k;
    t = 0;
    f = 0;
    k = 0;
    while (pwr !== 1'b0 && t < 900)
    begin
      @(posedge clk_i);
      t++;
    end
    lvl <= v;
    while (pwr !== 1'b1 && t < 2000)
    begin
      @(posedge clk_i);
      t++;
    end
    t = 0;
    while (pwr === 1'b1 && t < 500)
    begin
      @(posedge clk_i);
      t++;
      if (smp === 1'b1 && k == 0) f = t;
      k = k + int'(smp === 1'b1);
    end
    repeat (3) @(posedge clk_i);
    chk(f >= DIS - 1, 1);
    chk(k, 16);
    chk(supply, s);
    chk(main_current_o, lut[c]);
    rdc(6'h0d, c);
  endtask
  task automatic stop_test;
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: whole sequence needs roughly eleven thousand cycles
  initial
  begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    stop_test();
  end
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(pad_light_o, 0);
    rdc(6'h0f, 32'h0000_00a3);
    rdc(6'h0a, 0);
    for (int i = 0; i < 16; i++) rdc(6'h10 + 6'(i), lut[i]);
    rdc(6'h3f, 0);
    wr(6'h0d, 8'hff);
    rdc(6'h0d, 0);
    wr(6'h02, 8'h20);
    repeat (2) @(posedge clk_i);
    chk(pad_light_o, 1);
    wr(6'h02, 8'h00);
    wr(6'h01, 8'h55);
    wr(6'h00, 8'h08);
    repeat (3) @(posedge clk_i);
    chk(main_current_o, 8'h55);
    wr(6'h02, 8'h80);
    repeat (3) @(posedge clk_i);
    chk(main_current_o, 8'h33);
    // enable low must freeze the current even though its source moves
    ce <= 1'b0;
    cpi <= 8'h44;
    repeat (3) @(posedge clk_i);
    chk(main_current_o, 8'h33);
    ce <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(main_current_o, 8'h44);
    wr(6'h02, 8'h00);
    wr(6'h0a, 8'h10);
    wr(6'h01, 8'h5f);
    n = 0;
    while (main_current_o !== 8'h5f && n < 200)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(n >= 26 && n <= 34, 1);
    wr(6'h01, 8'h50);
    repeat (3) @(posedge clk_i);
    chk(main_current_o, 8'h50);
    wr(6'h0a, 8'h00);
    wr(6'h00, 8'h00);
    repeat (3) @(posedge clk_i);
    chk(main_current_o, 0);
    // duty (d+1)/16 over ten 64-cycle periods
    wr(6'h03, 8'h01);
    for (int d = 0; d < 16; d += 7)
    begin
      wr(6'h0e, 8'(d));
      repeat (64) @(posedge clk_i);
      n = 0;
      repeat (640) @(posedge clk_i) n += int'(pad_light_o === 1'b1);
      chk(n >= (d + 1) * 40 - 8 && n <= (d + 1) * 40 + 8, 1);
    end
    wr(6'h03, 8'h00);
    wr(6'h0c, 8'h00);
    wr(6'h00, 8'h88);
    for (int i = 0; i < 14; i++)
    begin
      if (i == 9) wr(6'h0c, 8'hc0);
      meas(tv[i], tc[i], i < 9);
    end
    wr(6'h0c, 8'hc7);
    meas(8'hfa, 4'hf, 1'b0);
    wr(6'h0c, 8'hc1);
    meas(8'h11, 4'h1, 1'b0);
    wr(6'h0c, 8'hc8);
    meas(8'h03, 4'h0, 1'b0);
    wr(6'h1f, 8'h77);
    lut[15] = 8'h77;
    meas(8'hff, 4'hf, 1'b0);
    wr(6'h0c, 8'h00);
    wr(6'h02, 8'h20);
    wr(6'h00, 8'h8a);
    meas(8'h0a, 4'h6, 1'b1);
    chk(pad_light_o, 1);
    meas(8'h27, 4'ha, 1'b1);
    chk(pad_light_o, 0);
    meas(8'h0e, 4'h7, 1'b1);
    chk(pad_light_o, 0);
    wr(6'h00, 8'h02);
    repeat (3) @(posedge clk_i);
    chk(pad_light_o, 1);
    stop_test();
  end
endmodule // tb_top
